// *** isrfc_pkg.sv ***
// constants and carrier types for the interrupt status / frame count block
package isrfc_pkg;

  // ------------------------------------------------------------------
  // register map: printed indices, byte address is four times index
  // ------------------------------------------------------------------
  localparam int                ADDR_W       = 12;
  localparam logic [7:0]        RXQC_IDX     = 8'h82;
  localparam logic [7:0]        ENA_IDX      = 8'h90;
  localparam logic [7:0]        STAT_IDX     = 8'h92;
  localparam logic [7:0]        FCNT_IDX     = 8'h9c;
  localparam logic [7:0]        PMC_IDX      = 8'hd4;
  localparam logic [ADDR_W-1:0] RXQC_ADDR    = {2'h0, RXQC_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] ENA_ADDR     = {2'h0, ENA_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] STAT_ADDR    = {2'h0, STAT_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] FCNT_ADDR    = {2'h0, FCNT_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] PMC_ADDR     = {2'h0, PMC_IDX, 2'h0};

  // ------------------------------------------------------------------
  // status bit positions and masks
  // ------------------------------------------------------------------
  localparam int                B_LINK       = 15;
  localparam int                B_TXD        = 14;
  localparam int                B_RXR        = 13;
  localparam int                B_OVR        = 11;
  localparam int                B_TXPS       = 9;
  localparam int                B_RXPS       = 8;
  localparam int                B_TXSA       = 6;
  localparam int                B_WF         = 5;
  localparam int                B_MP         = 4;
  localparam int                B_LD         = 3;
  localparam int                B_ED         = 2;
  localparam logic [15:0]       STAT_RESET   = 16'h0300;
  localparam logic [15:0]       STAT_W1C     = 16'heb40;
  localparam logic [15:0]       STAT_IMPL    = 16'heb7c;
  localparam logic [15:0]       REG_RESET    = 16'h0000;

  // enable bits that qualify the energy-detect kind
  localparam int                EN_ED        = 2;
  localparam int                EN_DED       = 0;

  // wake field of the power management register, one bit per flag
  localparam int                WAKE_LSB     = 2;
  localparam int                WAKE_MSB     = 5;
  localparam logic [3:0]        WAKE_FRAME_CLR = 4'h8;
  localparam logic [3:0]        WAKE_REMOTE_CLR = 4'h4;
  localparam logic [3:0]        WAKE_LINK_CLR  = 4'h2;
  localparam logic [3:0]        WAKE_ENERGY_CLR = 4'h1;

  // receive queue control: frame count threshold enable
  localparam int                RXQC_FCT_EN  = 5;

  localparam logic [1:0]        RESP_OKAY    = 2'h0;
  localparam logic [1:0]        RESP_SLVERR  = 2'h2;

  // ------------------------------------------------------------------
  // carrier for the event sources
  // ------------------------------------------------------------------
  typedef struct packed {
    logic link_up;
    logic tx_frame_sent;
    logic tx_queue_ready;
    logic rx_frame_done;
    logic rx_overrun;
    logic tx_stopped;
    logic rx_stopped;
    logic tx_space;
    logic wake_frame;
    logic remote_wake;
    logic linkup_wake;
    logic energy_wake;
  } isrfc_evt_s;

endpackage

// *** isrfc_top.sv ***
// interrupt status collection and receive frame count, AXI4-Lite slave
// Function
// - link change either way sets bit 15
// - queue flags clear only on written one
// - frame sent and queue ready sets 14
// - complete received frame sets bit 13 unless threshold enabled
// - receive overrun sets bit 11
// - transmit stop sets bit 9, reset one
// - receive stop sets bit 8, reset one
// - transmit space sets bit 6, W1C
// - wake frame sets 5, code 1000 clears
// - remote wake sets 4, code 0100 clears
// - linkup wake sets 3, code 0010 clears
// - energy wake sets 2, code 0001 clears
// - enables 2/0 tell plain or delayed energy
// - frame total captured at receive interrupt
// - count above threshold sets 13 when enabled
// - irq while any enabled flag set
// - reading status clears nothing
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/10ps
module isrfc_top (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic [isrfc_pkg::ADDR_W-1:0]  awaddr,
  input  wire logic [2:0]                    awprot,
  input  wire logic                          awvalid,
  output logic                               awready,
  input  wire logic [31:0]                   wdata,
  input  wire logic [3:0]                    wstrb,
  input  wire logic                          wvalid,
  output logic                               wready,
  output logic [1:0]                         bresp,
  output logic                               bvalid,
  input  wire logic                          bready,
  input  wire logic [isrfc_pkg::ADDR_W-1:0]  araddr,
  input  wire logic [2:0]                    arprot,
  input  wire logic                          arvalid,
  output logic                               arready,
  output logic [31:0]                        rdata,
  output logic [1:0]                         rresp,
  output logic                               rvalid,
  input  wire logic                          rready,
  input  wire isrfc_pkg::isrfc_evt_s         evt,
  input  wire logic [7:0]                    rx_frame_total_in,
  output logic                               irq,
  output logic                               energy_wake_plain,
  output logic                               energy_wake_delayed
);

  // ------------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------------
  logic [isrfc_pkg::ADDR_W-1:0] aw_addr_reg;
  logic                         aw_full_reg;
  logic [15:0]                  w_data_reg;
  logic [15:0]                  w_be_reg;
  logic                         w_full_reg;
  logic                         bvalid_reg;
  logic [1:0]                   bresp_reg;
  logic                         rvalid_reg;
  logic [1:0]                   rresp_reg;
  logic [31:0]                  rdata_reg;
  logic                         wr_do;
  logic                         rd_do;
  logic                         wr_hit;
  logic [15:0]                  wr_val;
  logic [15:0]                  rd_val;
  logic                         rd_hit;
  logic [15:0]                  ena_reg;
  logic [15:0]                  stat_reg;
  logic [15:0]                  stat_next;
  logic [15:0]                  stat_set;
  logic [15:0]                  stat_clr;
  logic [7:0]                   fct_reg;
  logic [7:0]                   fc_snap_reg;
  logic [15:0]                  rxqc_reg;
  logic [15:0]                  pmc_reg;
  logic                         link_q_reg;
  logic                         primed_reg;
  logic                         tx_pend_reg;
  logic                         over_q_reg;
  logic                         over_now;
  logic                         link_chg;
  logic                         irq_reg;

  // ------------------------------------------------------------------
  // write channels: address and data taken in either order
  // ------------------------------------------------------------------
  assign awready = !aw_full_reg && !bvalid_reg;
  assign wready  = !w_full_reg && !bvalid_reg;
  assign wr_do   = aw_full_reg && w_full_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (awvalid && awready) begin
      aw_full_reg <= 1'b1;
      aw_addr_reg <= awaddr;
    end else if (wr_do) begin
      aw_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_reg <= 1'b0;
      w_data_reg <= '0;
      w_be_reg   <= '0;
    end else if (wvalid && wready) begin
      w_full_reg <= 1'b1;
      w_data_reg <= wdata[15:0];
      w_be_reg   <= {{8{wstrb[1]}}, {8{wstrb[0]}}};
    end else if (wr_do) begin
      w_full_reg <= 1'b0;
    end
  end

  always_comb begin
    unique case (aw_addr_reg)
      isrfc_pkg::RXQC_ADDR,
      isrfc_pkg::ENA_ADDR,
      isrfc_pkg::STAT_ADDR,
      isrfc_pkg::FCNT_ADDR,
      isrfc_pkg::PMC_ADDR: wr_hit = 1'b1;
      default:             wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= isrfc_pkg::RESP_OKAY;
    end else if (wr_do) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_hit ? isrfc_pkg::RESP_OKAY : isrfc_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  assign bvalid = bvalid_reg;
  assign bresp  = bresp_reg;

  // ------------------------------------------------------------------
  // read channel: one cycle from address to data
  // ------------------------------------------------------------------
  assign arready = !rvalid_reg;
  assign rd_do   = arvalid && arready;

  always_comb begin
    rd_hit = 1'b1;
    unique case (araddr)
      isrfc_pkg::RXQC_ADDR:   rd_val = rxqc_reg;
      isrfc_pkg::ENA_ADDR:    rd_val = ena_reg;
      isrfc_pkg::STAT_ADDR:   rd_val = stat_reg;
      isrfc_pkg::FCNT_ADDR:   rd_val = {fc_snap_reg, fct_reg};
      isrfc_pkg::PMC_ADDR:    rd_val = pmc_reg;
      default: begin
        rd_val = 16'h0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  // status read has no side effect on the flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= isrfc_pkg::RESP_OKAY;
      rdata_reg  <= '0;
    end else if (rd_do) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= rd_hit ? isrfc_pkg::RESP_OKAY : isrfc_pkg::RESP_SLVERR;
      rdata_reg  <= {16'h0000, rd_val};
    end else if (rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign rvalid = rvalid_reg;
  assign rresp  = rresp_reg;
  assign rdata  = rdata_reg;

  // ------------------------------------------------------------------
  // plain read-write registers, byte lanes honoured
  // ------------------------------------------------------------------
  function automatic logic [15:0] merge(input logic [15:0] old_v);
    merge = (old_v & ~w_be_reg) | (w_data_reg & w_be_reg);
  endfunction

  assign wr_val = merge(pmc_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ena_reg  <= isrfc_pkg::REG_RESET;
      rxqc_reg <= isrfc_pkg::REG_RESET;
      pmc_reg  <= isrfc_pkg::REG_RESET;
      fct_reg  <= isrfc_pkg::REG_RESET[7:0];
    end else if (wr_do) begin
      if (aw_addr_reg == isrfc_pkg::ENA_ADDR)
        ena_reg <= merge(ena_reg);
      if (aw_addr_reg == isrfc_pkg::RXQC_ADDR)
        rxqc_reg <= merge(rxqc_reg);
      // wake field is a command, it never holds a value
      if (aw_addr_reg == isrfc_pkg::PMC_ADDR)
        pmc_reg <= wr_val & ~{10'h000, 4'hf, 2'h0};
      if (aw_addr_reg == isrfc_pkg::FCNT_ADDR && w_be_reg[0])
        fct_reg <= w_data_reg[7:0];
    end
  end

  // ------------------------------------------------------------------
  // event conditioning
  // ------------------------------------------------------------------
  // first cycle after reset only samples the link, so a link already up
  // at release does not look like a change
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_q_reg <= 1'b0;
      primed_reg <= 1'b0;
    end else begin
      link_q_reg <= evt.link_up;
      primed_reg <= 1'b1;
    end
  end

  assign link_chg = primed_reg && (evt.link_up != link_q_reg);

  // a sent frame waits until the queue can take new frames
  always_ff @(posedge aclk) begin
    if (!aresetn)
      tx_pend_reg <= 1'b0;
    else if (tx_pend_reg && evt.tx_queue_ready)
      tx_pend_reg <= evt.tx_frame_sent;
    else if (evt.tx_frame_sent)
      tx_pend_reg <= 1'b1;
  end

  // threshold flag is edge triggered on the crossing
  assign over_now = rxqc_reg[isrfc_pkg::RXQC_FCT_EN]
                    && (rx_frame_total_in > fct_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn)
      over_q_reg <= 1'b0;
    else
      over_q_reg <= over_now;
  end

  // ------------------------------------------------------------------
  // status register: set wins over clear in the same cycle
  // ------------------------------------------------------------------
  always_comb begin
    stat_set = 16'h0000;
    stat_set[isrfc_pkg::B_LINK] = link_chg;
    stat_set[isrfc_pkg::B_TXD]  =
      tx_pend_reg && evt.tx_queue_ready;
    stat_set[isrfc_pkg::B_RXR]  =
      (evt.rx_frame_done && !rxqc_reg[isrfc_pkg::RXQC_FCT_EN])
      || (over_now && !over_q_reg);
    stat_set[isrfc_pkg::B_OVR]  = evt.rx_overrun;
    stat_set[isrfc_pkg::B_TXPS] = evt.tx_stopped;
    stat_set[isrfc_pkg::B_RXPS] = evt.rx_stopped;
    stat_set[isrfc_pkg::B_TXSA] = evt.tx_space;
    stat_set[isrfc_pkg::B_WF]   = evt.wake_frame;
    stat_set[isrfc_pkg::B_MP]   = evt.remote_wake;
    stat_set[isrfc_pkg::B_LD]   = evt.linkup_wake;
    stat_set[isrfc_pkg::B_ED]   = evt.energy_wake;
    stat_clr = 16'h0000;
    if (wr_do && aw_addr_reg == isrfc_pkg::STAT_ADDR)
      stat_clr = w_data_reg & w_be_reg & isrfc_pkg::STAT_W1C;
    if (wr_do && aw_addr_reg == isrfc_pkg::PMC_ADDR && w_be_reg[0])
      stat_clr[isrfc_pkg::WAKE_MSB:isrfc_pkg::WAKE_LSB] =
        w_data_reg[isrfc_pkg::WAKE_MSB:isrfc_pkg::WAKE_LSB];
    stat_next = ((stat_reg & ~stat_clr) | stat_set)
                & isrfc_pkg::STAT_IMPL;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      stat_reg <= isrfc_pkg::STAT_RESET;
    else
      stat_reg <= stat_next;
  end

  // count seen by the host belongs to the receive interrupt instant
  always_ff @(posedge aclk) begin
    if (!aresetn)
      fc_snap_reg <= isrfc_pkg::REG_RESET[7:0];
    else if (stat_set[isrfc_pkg::B_RXR])
      fc_snap_reg <= rx_frame_total_in;
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn)
      irq_reg <= 1'b0;
    else
      irq_reg <= |(stat_reg & ena_reg);
  end

  assign irq = irq_reg;

  assign energy_wake_plain   = stat_reg[isrfc_pkg::B_ED]
                               && ena_reg[isrfc_pkg::EN_ED]
                               && !ena_reg[isrfc_pkg::EN_DED];
  assign energy_wake_delayed = stat_reg[isrfc_pkg::B_ED]
                               && ena_reg[isrfc_pkg::EN_ED]
                               && ena_reg[isrfc_pkg::EN_DED];

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  link_change_a: assert property (link_chg |=> stat_reg[15])
    else $error("link change did not set status bit 15");

  w1c_clear_a: assert property (
    (wr_do && aw_addr_reg == isrfc_pkg::STAT_ADDR && w_be_reg[1]
     && w_data_reg[11] && !evt.rx_overrun)
    |=> !stat_reg[11])
    else $error("written one did not clear overrun flag");

  w1c_zero_a: assert property (
    (wr_do && aw_addr_reg == isrfc_pkg::STAT_ADDR && !w_data_reg[8]
     && stat_reg[8]) |=> stat_reg[8])
    else $error("written zero cleared receive stop flag");

  tx_done_a: assert property (
    (tx_pend_reg && evt.tx_queue_ready) |=> stat_reg[14])
    else $error("transmit done flag missing");

  stop_flags_a: assert property (
    (evt.rx_overrun || evt.tx_stopped || evt.rx_stopped || evt.tx_space)
    |=> (!$past(evt.rx_overrun) || stat_reg[isrfc_pkg::B_OVR])
        && (!$past(evt.tx_stopped) || stat_reg[isrfc_pkg::B_TXPS])
        && (!$past(evt.rx_stopped) || stat_reg[isrfc_pkg::B_RXPS])
        && (!$past(evt.tx_space) || stat_reg[isrfc_pkg::B_TXSA]))
    else $error("event flag not set");

  wake_clear_a: assert property (
    (wr_do && aw_addr_reg == isrfc_pkg::PMC_ADDR && w_be_reg[0]
     && w_data_reg[5:2] == isrfc_pkg::WAKE_FRAME_CLR && !evt.wake_frame
     && !evt.remote_wake && !evt.linkup_wake && !evt.energy_wake)
    |=> !stat_reg[5] && $stable(stat_reg[4:2]))
    else $error("wake code cleared wrong flag");

  energy_kind_a: assert property (
    !(energy_wake_plain && energy_wake_delayed))
    else $error("energy wake reported as both kinds");

  rx_thresh_a: assert property (
    (over_now && !over_q_reg) |=> stat_reg[13]
    ##0 fc_snap_reg == $past(rx_frame_total_in))
    else $error("threshold crossing missed or count not captured");

  irq_level_a: assert property (
    ##1 irq == (($past(stat_reg) & $past(ena_reg)) != 16'h0000))
    else $error("interrupt output disagrees with flags");

  read_keep_a: assert property (
    (rd_do && araddr == isrfc_pkg::STAT_ADDR && !wr_do)
    |=> ($past(stat_reg) & ~stat_reg) == 16'h0000)
    else $error("status read cleared a flag");

  reserved_zero_a: assert property (
    (stat_reg & ~isrfc_pkg::STAT_IMPL) == 16'h0000)
    else $error("reserved status bit set");

  rd_answer_a: assert property (rd_do |=> rvalid)
    else $error("read not answered next cycle");

  write_cov_c: cover property (wr_do && aw_addr_reg == isrfc_pkg::STAT_ADDR);
  irq_cov_c:   cover property (!irq ##1 irq);
  thresh_cov_c: cover property (over_now && !over_q_reg);
  wake_cov_c:  cover property (stat_reg[5] ##[1:20] !stat_reg[5]);

endmodule // isrfc_top

// *** isrfc_src.sv ***
// event source model for the queue manager and phy side of the block
`timescale 1ns/10ps
module isrfc_src (
  input  wire logic             aclk,
  output isrfc_pkg::isrfc_evt_s evt,
  output logic [7:0]            rx_frame_total_in
);
  // ----------------------------------------------------------------
  // sources idle low, queue empty
  // ----------------------------------------------------------------
  initial begin
    evt = '0;
    rx_frame_total_in = 8'h00;
  end

  // changes land just after an edge, like the real queue logic
  task automatic level(input int b, input logic v);
    @(posedge aclk);
    evt[b] <= v;
  endtask

  // one-cycle event; a longer one would re-set the flag each cycle
  task automatic pulse(input int b);
    level(b, 1'b1);
    level(b, 1'b0);
  endtask

  task automatic total(input logic [7:0] v);
    @(posedge aclk);
    rx_frame_total_in <= v;
  endtask
endmodule // isrfc_src

// *** tb_top.sv ***
// self-checking bench for the interrupt status and frame count block
`timescale 1ns/10ps
module tb_top;
  logic                     aclk, aresetn;
  logic [11:0]              awaddr, araddr;
  logic [2:0]               awprot, arprot;
  logic                     awvalid, awready, wvalid, wready;
  logic                     bvalid, bready, arvalid, arready;
  logic                     rvalid, rready, irq;
  logic                     energy_wake_plain, energy_wake_delayed;
  logic [31:0]              wdata, rdata, d;
  logic [3:0]               wstrb;
  logic [1:0]               bresp, rresp, r;
  logic [7:0]               rx_frame_total_in, thr;
  logic [15:0]              seed, exp_st;
  isrfc_pkg::isrfc_evt_s    evt;
  int                       n_errors, compares, cyc, i;
  int                       ev_idx[8] = '{7, 6, 5, 4, 3, 2, 1, 0};
  int                       ev_bit[8] = '{11, 9, 8, 6, 5, 4, 3, 2};

  isrfc_top isrfc_top_i (.aclk, .aresetn, .awaddr, .awprot, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arprot, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .evt, .rx_frame_total_in, .irq, .energy_wake_plain,
    .energy_wake_delayed);
  isrfc_src isrfc_src_i (.aclk, .evt, .rx_frame_total_in);

  // ----------------------------------------------------------------
  // clock, hang guard, checking
  // ----------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // whole run is about two hundred and fifty cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      results();
    end
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic chk(input string w, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic results();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // bus master; each wait ends only on the slave's answer
  // ----------------------------------------------------------------
  task automatic wr(input logic [11:0] a, input logic [15:0] v,
                    output logic [1:0] rs);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {16'h0000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    rs = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] v,
                    output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [15:0] e,
                      input string w);
    rd(a, d, r);
    chk(w, {16'h0000, e}, d);
  endtask

  task automatic done_t(input string w);
    $display("test %s finished", w);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, awprot, arprot, wdata} = '0;
    wstrb = 4'hf;
    seed = 16'h0010;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(isrfc_pkg::STAT_ADDR, 16'h0300, "status");
    rchk(isrfc_pkg::ENA_ADDR, 16'h0000, "enable");
    rchk(isrfc_pkg::FCNT_ADDR, 16'h0000, "frame count");
    done_t("reset");
    wr(isrfc_pkg::STAT_ADDR, 16'hffff, r);
    exp_st = 16'h0000;
    rchk(isrfc_pkg::STAT_ADDR, exp_st, "status");
    for (i = 0; i < 8; i++) begin
      isrfc_src_i.pulse(ev_idx[i]);
      exp_st |= 16'h0001 << ev_bit[i];
      rchk(isrfc_pkg::STAT_ADDR, exp_st, "status");
      rchk(isrfc_pkg::STAT_ADDR, exp_st, "status again");
    end
    wr(isrfc_pkg::STAT_ADDR, 16'h0000, r);
    rchk(isrfc_pkg::STAT_ADDR, exp_st, "status");
    wr(isrfc_pkg::STAT_ADDR, 16'hffff, r);
    exp_st &= 16'h003c;
    rchk(isrfc_pkg::STAT_ADDR, exp_st, "status");
    for (i = 0; i < 4; i++) begin
      wr(isrfc_pkg::PMC_ADDR, {10'h000, 4'h8 >> i, 2'h0}, r);
      exp_st &= ~(16'h0020 >> i);
      rchk(isrfc_pkg::STAT_ADDR, exp_st, "status");
    end
    done_t("flags");
    for (i = 0; i < 2; i++) begin
      isrfc_src_i.level(11, ~i[0]);
      rchk(isrfc_pkg::STAT_ADDR, 16'h8000, "status");
      wr(isrfc_pkg::STAT_ADDR, 16'h8000, r);
    end
    isrfc_src_i.pulse(10);
    rchk(isrfc_pkg::STAT_ADDR, 16'h0000, "status");
    isrfc_src_i.level(9, 1'b1);
    rchk(isrfc_pkg::STAT_ADDR, 16'h4000, "status");
    isrfc_src_i.level(9, 1'b0);
    wr(isrfc_pkg::STAT_ADDR, 16'h4000, r);
    done_t("link and transmit");
    isrfc_src_i.total(8'h05);
    isrfc_src_i.pulse(8);
    rchk(isrfc_pkg::STAT_ADDR, 16'h2000, "status");
    rchk(isrfc_pkg::FCNT_ADDR, 16'h0500, "frame count");
    wr(isrfc_pkg::STAT_ADDR, 16'h2000, r);
    rchk(isrfc_pkg::STAT_ADDR, 16'h0000, "status");
    seed = lfsr(seed);
    thr = {2'h0, seed[5:0]} + 8'h01;
    isrfc_src_i.total(8'h00);
    wr(isrfc_pkg::FCNT_ADDR, {8'hff, thr}, r);
    rchk(isrfc_pkg::FCNT_ADDR, {8'h05, thr}, "frame count");
    wr(isrfc_pkg::RXQC_ADDR, 16'h0020, r);
    isrfc_src_i.total(thr);
    rchk(isrfc_pkg::STAT_ADDR, 16'h0000, "status");
    isrfc_src_i.total(thr + 8'h01);
    rchk(isrfc_pkg::STAT_ADDR, 16'h2000, "status");
    rchk(isrfc_pkg::FCNT_ADDR, {thr + 8'h01, thr}, "count");
    wr(isrfc_pkg::RXQC_ADDR, 16'h0000, r);
    wr(isrfc_pkg::STAT_ADDR, 16'h2000, r);
    done_t("receive");
    isrfc_src_i.pulse(0);
    exp_st = 16'h0004;
    rchk(isrfc_pkg::STAT_ADDR, exp_st, "status");
    seed = lfsr(seed);
    wr(isrfc_pkg::ENA_ADDR, seed, r);
    rchk(isrfc_pkg::ENA_ADDR, seed, "enable");
    chk("irq", {31'h0, |(exp_st & seed)}, {31'h0, irq});
    for (i = 0; i < 3; i++) begin
      wr(isrfc_pkg::ENA_ADDR, {13'h0000, i < 2, 1'b0, i > 0}, r);
      repeat (2) @(posedge aclk);
      chk("irq", {31'h0, i < 2}, {31'h0, irq});
      chk("plain", {31'h0, i == 0}, {31'h0, energy_wake_plain});
      chk("delay", 32'(i == 1), {31'h0, energy_wake_delayed});
    end
    done_t("interrupt");
    wr(12'h004, 16'hffff, r);
    chk("bresp", {30'h0, isrfc_pkg::RESP_SLVERR}, {30'h0, r});
    rd(12'h004, d, r);
    chk("rresp", {30'h0, isrfc_pkg::RESP_SLVERR}, {30'h0, r});
    chk("rdata", 32'h0000_0000, d);
    done_t("unmapped");
    results();
  end
endmodule // tb_top
